//--- include/dsm_pkg.sv
package dsm_pkg;
	// Digital model of the analog input: signed differential sample.
	localparam int DSM_IN_W       = 16;
	// Internal loop accumulators are wider to hold integrator swings.
	localparam int DSM_ACC_W      = 24;
	// Full scale of the feedback DAC, one code above the clipping level.
	localparam logic signed [DSM_ACC_W-1:0] DSM_DAC_FS = 24'sh008000;
	// Linear range magnitude, 1 V of 1.25 V clipping, as a code.
	localparam logic [DSM_IN_W-1:0] DSM_LIN_MAX = 16'h6666;
	localparam logic [DSM_IN_W-1:0] DSM_CLIP_LVL = 16'h7fff;
	localparam int DSM_CHOP_DIV   = 32;
	// Chopper half period: a toggle every 16 rises gives one full
	// chopping cycle per 32 sample clocks.
	localparam logic [4:0] DSM_CHOP_LAST = 5'h0f;
	localparam int DSM_CLIP_PER   = 128;
	localparam logic [6:0] DSM_CLIP_LAST = 7'h7f;
	// Reset values.
	localparam logic DSM_DOUT_RST = 1'b0;
	localparam logic [2:0] DSM_SYNC_RST = 3'h0;
	// Settling time, microseconds, and the system clock rate.
	localparam int DSM_SETTLE_US  = 250;
	localparam int DSM_CLK_MHZ    = 125;
	localparam int DSM_SETTLE_CYC = DSM_SETTLE_US * DSM_CLK_MHZ;
	localparam int DSM_SETTLE_W   = 16;
endpackage

//--- core/dsm_pin_sync.sv
`timescale 1ns/1ps
module dsm_pin_sync (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Asynchronous pin and its filtered level.
	input  wire logic pin_in,
	output logic      level_out
);
	import dsm_pkg::*;

	logic [2:0] sh_ff;
	logic [2:0] nxt_sh;
	logic       lvl_ff;
	logic       nxt_lvl;

	always_comb begin
		nxt_sh = {sh_ff[1:0], pin_in};
		nxt_lvl = lvl_ff;
		// Stage 0 feeds stage 1 only; stages 1 and 2 must agree.
		if (sh_ff[1] == sh_ff[2]) begin
			nxt_lvl = sh_ff[2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_ff <= DSM_SYNC_RST;
			lvl_ff <= 1'b0;
		end else begin
			sh_ff <= nxt_sh;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level_out = lvl_ff;
endmodule

//--- core/dsm_bitstream.sv
`timescale 1ns/1ps
// Overview of operation
// - One output bit per sample clock period, synchronous to that clock.
// - Average density of ones follows the differential input.
// - Input chopper toggles every 16 sample clocks, one full cycle per 32.
// - Feedback DAC follows each comparator decision on the next pulse.
// - Linear behaviour only inside plus or minus one volt input range.
// - Uncoded output changes only after sample clock rising edges.
// - Manchester output changes after both sample clock edges.
// - Line code select high gives clock XOR data, else uncoded.
// - With the sample clock stopped, conversion halts and output holds.
// - At clipping, one opposite bit appears every 128 bits.
// - Common-mode fault holds the output steadily high.
module dsm_bitstream (
	// System clock and reset.
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Link pins from the filter side.
	input  wire logic                          sample_clock_in,
	input  wire logic                          line_code_select,
	// Digitised model of the analog front end.
	input  wire logic signed [dsm_pkg::DSM_IN_W-1:0] analog_diff_in,
	input  wire logic                          cm_fault_in,
	// Outputs.
	output logic                               bitstream_out,
	output logic                               in_linear_range,
	output logic                               chopper_phase,
	output logic                               analog_settled
);
	import dsm_pkg::*;

	logic sclk_lvl;
	logic code_sel_lvl;
	logic sclk_d_ff;
	logic rise;
	logic fall;

	dsm_pin_sync u_sclk (
		.clk       (clk),
		.rst       (rst),
		.pin_in    (sample_clock_in),
		.level_out (sclk_lvl)
	);

	dsm_pin_sync u_code_sel (
		.clk       (clk),
		.rst       (rst),
		.pin_in    (line_code_select),
		.level_out (code_sel_lvl)
	);

	assign rise = sclk_lvl & ~sclk_d_ff;
	assign fall = ~sclk_lvl & sclk_d_ff;

	function automatic logic [DSM_IN_W-1:0] mag(
		input logic signed [DSM_IN_W-1:0] v
	);
		mag = v[DSM_IN_W-1] ? DSM_IN_W'(-v) : DSM_IN_W'(v);
	endfunction

	logic signed [DSM_ACC_W-1:0] int1_ff;
	logic signed [DSM_ACC_W-1:0] int2_ff;
	logic signed [DSM_ACC_W-1:0] nxt_int1;
	logic signed [DSM_ACC_W-1:0] nxt_int2;
	logic signed [DSM_ACC_W-1:0] vin;
	logic signed [DSM_ACC_W-1:0] dac;
	logic signed [DSM_ACC_W-1:0] sum4;
	logic        bit_ff;
	logic        nxt_bit;
	logic [4:0]  chop_cnt_ff;
	logic [4:0]  nxt_chop_cnt;
	logic        chop_ff;
	logic        nxt_chop;
	logic [6:0]  clip_cnt_ff;
	logic [6:0]  nxt_clip_cnt;
	logic        dout_ff;
	logic        nxt_dout;
	logic        lin_ff;
	logic        nxt_lin;
	logic [DSM_SETTLE_W-1:0] settle_ff;
	logic [DSM_SETTLE_W-1:0] nxt_settle;
	logic        settled_ff;
	logic        nxt_settled;
	logic        clipping;

	always_comb begin
		vin = DSM_ACC_W'(analog_diff_in);
		dac = bit_ff ? DSM_DAC_FS : -DSM_DAC_FS;
		sum4 = int2_ff + (int1_ff <<< 1) + vin;
		clipping = mag(analog_diff_in) >= DSM_CLIP_LVL;
		nxt_int1 = int1_ff;
		nxt_int2 = int2_ff;
		nxt_bit = bit_ff;
		nxt_chop_cnt = chop_cnt_ff;
		nxt_chop = chop_ff;
		nxt_clip_cnt = clip_cnt_ff;
		nxt_lin = lin_ff;
		nxt_dout = dout_ff;
		nxt_settle = settle_ff;
		nxt_settled = settled_ff;
		if (rise) begin
			// DAC uses last decision.
			// Integrators hold while clipping, as forced bits would wind them up.
			if (!clipping) begin
				nxt_int1 = int1_ff + vin - dac;
				nxt_int2 = int2_ff + int1_ff;
			end
			// comparator on feed-forward sum.
			// Deciding on the updated state avoids a loop delay that diverges.
			sum4 = nxt_int2 + (nxt_int1 <<< 1) + vin;
			nxt_bit = ~sum4[DSM_ACC_W-1];
			if (clipping) begin
				nxt_clip_cnt = clip_cnt_ff + 7'h01;
				nxt_bit = ~analog_diff_in[DSM_IN_W-1];
				if (clip_cnt_ff == DSM_CLIP_LAST) begin
					nxt_bit = analog_diff_in[DSM_IN_W-1];
				end
			end else begin
				nxt_clip_cnt = 7'h00;
			end
			nxt_chop_cnt = chop_cnt_ff + 5'h01;
			if (chop_cnt_ff == DSM_CHOP_LAST) begin
				nxt_chop = ~chop_ff;
				nxt_chop_cnt = 5'h00;
			end
			nxt_lin = mag(analog_diff_in) <= DSM_LIN_MAX;
			if (settle_ff != DSM_SETTLE_W'(DSM_SETTLE_CYC / 8)) begin
				nxt_settle = settle_ff + 16'h0001;
			end
			nxt_settled = nxt_settle == DSM_SETTLE_W'(DSM_SETTLE_CYC / 8);
		end
		if (cm_fault_in) begin
			nxt_dout = 1'b1;
		end else if (code_sel_lvl) begin
			if (rise) begin
				nxt_dout = nxt_bit ^ 1'b1;
			end else if (fall) begin
				nxt_dout = bit_ff;
			end
		end else if (rise) begin
			nxt_dout = nxt_bit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_d_ff <= 1'b0;
			int1_ff <= '0;
			int2_ff <= '0;
			bit_ff <= 1'b0;
			chop_cnt_ff <= 5'h00;
			chop_ff <= 1'b0;
			clip_cnt_ff <= 7'h00;
			dout_ff <= DSM_DOUT_RST;
			lin_ff <= 1'b0;
			settle_ff <= '0;
			settled_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_lvl;
			int1_ff <= nxt_int1;
			int2_ff <= nxt_int2;
			bit_ff <= nxt_bit;
			chop_cnt_ff <= nxt_chop_cnt;
			chop_ff <= nxt_chop;
			clip_cnt_ff <= nxt_clip_cnt;
			dout_ff <= nxt_dout;
			lin_ff <= nxt_lin;
			settle_ff <= nxt_settle;
			settled_ff <= nxt_settled;
		end
	end

	assign bitstream_out = dout_ff;
	assign in_linear_range = lin_ff;
	assign chopper_phase = chop_ff;
	assign analog_settled = settled_ff;

	// Settle counts sample clock periods, not system cycles, so the time
	// scales with the link rate; the count assumes about 16 MHz.

	a_hold_no_edge: assert property (@(posedge clk) disable iff (rst)
		(!rise && !fall && !cm_fault_in) |=> $stable(dout_ff))
		else $error("output moved without a clock edge");
	a_fault_high: assert property (@(posedge clk) disable iff (rst)
		cm_fault_in |=> dout_ff)
		else $error("fault did not force output high");
	a_uncoded_rise: assert property (@(posedge clk) disable iff (rst)
		(!code_sel_lvl && !cm_fault_in && rise) |=> dout_ff == bit_ff)
		else $error("uncoded output differs from bit");
	a_manch_fall: assert property (@(posedge clk) disable iff (rst)
		(code_sel_lvl && !cm_fault_in && fall) |=> dout_ff == $past(bit_ff))
		else $error("manchester low half wrong");
	a_manch_rise: assert property (@(posedge clk) disable iff (rst)
		(code_sel_lvl && !cm_fault_in && rise) |=> dout_ff == !bit_ff)
		else $error("manchester high half wrong");
	a_chop_rate: assert property (@(posedge clk) disable iff (rst)
		(rise && chop_cnt_ff == DSM_CHOP_LAST) |=> chop_ff != $past(chop_ff))
		else $error("chopper did not toggle");
	a_chop_hold: assert property (@(posedge clk) disable iff (rst)
		(rise && chop_cnt_ff != DSM_CHOP_LAST) |=> $stable(chop_ff))
		else $error("chopper toggled early");
	a_clip_mark: assert property (@(posedge clk) disable iff (rst)
		(rise && clipping && clip_cnt_ff == DSM_CLIP_LAST)
		|=> bit_ff == $past(analog_diff_in[DSM_IN_W-1]))
		else $error("clip marker bit missing");
	a_dac_update: assert property (@(posedge clk) disable iff (rst)
		(rise && !clipping)
		|=> int1_ff == $past(int1_ff) + $past(vin) - $past(dac))
		else $error("integrator ignored DAC");
	a_clip_freeze: assert property (@(posedge clk) disable iff (rst)
		(rise && clipping) |=> $stable(int1_ff) && $stable(int2_ff))
		else $error("integrators moved while clipping");
	a_one_bit: assert property (@(posedge clk) disable iff (rst)
		!rise |=> $stable(bit_ff))
		else $error("bit changed off rising edge");
endmodule

//--- verif/dsm_filter_model.sv
`timescale 1ns/1ps
module dsm_filter_model (
	// Control and link.
	input  wire logic run,
	input  wire logic bitstream_out,
	output logic      sample_clock_in,
	// Counts seen at the link.
	output int        n_rise,
	output int        n_ones,
	output int        n_edges
);
	initial begin
		sample_clock_in = 1'b0;
	end
	// clock, even duty.
	// It stops low between frames; run is looked at only a whole period
	// after a rise, so dropping it on the last fall adds no extra rise.
	always begin
		wait (run);
		sample_clock_in = 1'b1;
		#62.5 sample_clock_in = 1'b0;
		#62.5;
	end
	// latch and average.
	// Latched on the fall, as the device answers a few cycles late.
	always @(negedge sample_clock_in) begin
		n_rise <= n_rise + 1;
		n_ones <= n_ones + int'(bitstream_out);
	end
	always @(bitstream_out) n_edges <= n_edges + 1;
endmodule

//--- verif/tb_dsm_bitstream.sv
`timescale 1ns/1ps
module tb_dsm_bitstream;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 code_sel = 1'b0;
	logic                 fault = 1'b0;
	logic                 run = 1'b0;
	logic signed [15:0]   ain = 16'sh0000;
	logic                 sclk, dout, lin, chop, settled;
	int                   nr, no, ne, nc, fail_count, n_checks;
	always #4 clk = ~clk;
	always @(chop) nc++;
	dsm_bitstream dsm_bitstream_i (.clk(clk), .rst(rst),
		.sample_clock_in(sclk), .line_code_select(code_sel),
		.analog_diff_in(ain), .cm_fault_in(fault), .bitstream_out(dout),
		.in_linear_range(lin), .chopper_phase(chop),
		.analog_settled(settled));
	dsm_filter_model dsm_filter_model_i (.run(run), .bitstream_out(dout),
		.sample_clock_in(sclk), .n_rise(nr), .n_ones(no), .n_edges(ne));
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", s, e, g);
		end
	endtask
	task automatic chk_rng(string s, int lo, int hi, int g);
		n_checks++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	task automatic bits(int n);
		int b;
		b = nr;
		run = 1'b1;
		wait (nr >= b + n);
		run = 1'b0;
		repeat (20) @(posedge clk);
		#1;
	endtask
	task automatic set_in(logic signed [15:0] v, logic m, logic f);
		@(posedge clk);
		#1;
		ain = v;
		code_sel = m;
		fault = f;
	endtask
	task automatic t_settle;
		bits(3800);
		chk("settled", 0, settled);
		bits(120);
		chk("settled", 1, settled);
	endtask
	task automatic t_density(logic signed [15:0] v, int lo, int hi);
		int o, c;
		set_in(v, 1'b0, 1'b0);
		bits(64);
		o = no;
		c = nc;
		bits(256);
		chk_rng("ones", lo, hi, no - o);
		chk("chop", 16, nc - c);
	endtask
	task automatic t_modes;
		int e, o;
		chk("linear", 0, lin);
		e = ne;
		bits(256);
		chk_rng("edges", 1, 4, ne - e);
		set_in(16'sh7fff, 1'b1, 1'b0);
		bits(8);
		e = ne;
		bits(64);
		chk_rng("edges", 120, 132, ne - e);
		set_in(16'sh0000, 1'b0, 1'b1);
		o = no;
		bits(32);
		chk("fault", 32, no - o);
	endtask
	task automatic t_hold;
		logic d;
		set_in(16'sh4000, 1'b0, 1'b0);
		bits(33);
		d = dout;
		set_in(-16'sh4000, 1'b0, 1'b0);
		repeat (300) @(posedge clk);
		chk("hold", d, dout);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// About 5600 sample periods of 125 ns are planned; allow some slack.
	initial begin
		#760000;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		t_settle();
		t_density(16'sh0000, 118, 138);
		t_density(16'sh6666, 220, 240);
		chk("linear", 1, lin);
		t_density(-16'sh7fff, 2, 2);
		t_density(16'sh7fff, 254, 254);
		t_modes();
		t_hold();
		stop_test();
	end
endmodule
